// ===== core/crypto_ase_pkg.sv
// package for the crypto extension decoder: encodings, decode results and config bits
`default_nettype none
package crypto_ase_pkg;
    localparam logic [5:0] OPC_FIRST_SPECIAL = 6'h00;
    localparam logic [5:0] OPC_SECOND_SPECIAL = 6'h1c;
    localparam logic [3:0] OPC_COPROC_HI = 4'h4;
    localparam logic [5:0] FN_SHIFT_RIGHT_LOGICAL = 6'h02;
    localparam logic [5:0] FN_SHIFT_RIGHT_VARIABLE = 6'h06;
    localparam logic [5:0] FN_MOVE_FROM_LOW = 6'h12;
    localparam logic [5:0] FN_MOVE_TO_LOW = 6'h13;
    localparam logic [5:0] FN_UNSIGNED_MULTIPLY = 6'h19;
    localparam logic [5:0] FN_UNSIGNED_MULTIPLY_ADD = 6'h01;
    localparam logic [5:0] FN_INDEXED_LOAD_GROUP = 6'h08;
    localparam logic [5:0] FN_DEBUG_BREAK = 6'h3f;
    localparam logic [4:0] SA_PLAIN = 5'h00;
    localparam logic [4:0] SA_EXT_ACCUM = 5'h01;
    localparam logic [4:0] SA_POLY = 5'h11;
    localparam logic [4:0] SA_PERMUTE = 5'h12;
    localparam logic [4:0] SA_SCALED_WORD = 5'h01;
    localparam int ROT_IMM_BIT = 21;
    localparam int ROT_VAR_BIT = 6;
    localparam logic [2:0] PERMUTE_BITS = 3'h6;
    localparam logic [1:0] SCALE_SHIFT = 2'h2;
    localparam logic [1:0] REL_TWO = 2'h2;
    localparam logic [1:0] REL_THREE = 2'h3;

    typedef enum logic [4:0] {
        OP_NONE = 5'b00000,
        OP_SHIFT_RIGHT_LOGICAL = 5'b00001,
        OP_ROTATE_RIGHT_IMM = 5'b00010,
        OP_SHIFT_RIGHT_VARIABLE = 5'b00011,
        OP_ROTATE_RIGHT_VAR = 5'b00100,
        OP_MOVE_FROM_LOW = 5'b00101,
        OP_MOVE_FROM_EXT_ACCUM = 5'b00110,
        OP_MOVE_TO_LOW = 5'b00111,
        OP_MOVE_TO_EXT_ACCUM = 5'b01000,
        OP_UNSIGNED_MULTIPLY = 5'b01001,
        OP_POLY_MULTIPLY = 5'b01010,
        OP_UNSIGNED_MULTIPLY_ADD = 5'b01011,
        OP_POLY_MULTIPLY_ADD = 5'b01100,
        OP_PARTIAL_PERMUTE = 5'b01101,
        OP_SCALED_INDEXED_WORD_LOAD = 5'b01110,
        OP_DEBUG_BREAK = 5'b01111
    } dec_op_t;

    // accumulator and writeback steering for the execute stage
    typedef struct packed {
        logic writesGpr;
        logic gprFromLo;
        logic loFromHi;
        logic hiFromAcxZext;
        logic loFromGpr;
        logic hiFromLo;
        logic acxFromHi;
        logic clearsAcx;
        logic polyArith;
        logic [2:0] accumShift;
        logic [1:0] indexShift;
    } ctl_t;

    typedef struct packed {
        logic smallPage;
        logic readExecInhibit;
        logic readInhibitWritable;
        logic execInhibitWritable;
        logic contextCfgPresent;
        logic extensionPresent;
        logic page2kSupport;
        logic page1kSupport;
        logic readOnlyProt;
        logic writeOnlyProt;
        logic execOnlyProt;
    } cfg_t;

    typedef struct packed {
        dec_op_t op;
        logic resInstr;
        logic coprocUnusable;
        logic [1:0] unit;
    } dec_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic fault;
    } agu_t;
endpackage
`default_nettype wire

// ===== core/scaled_load_agu.sv
// address generator for the scaled indexed word load
`default_nettype none
module scaled_load_agu (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [31:0] baseValue,
    input wire logic [31:0] indexValue,
    output logic addrValid,
    output logic [31:0] addr,
    output logic addrFault
);
    import crypto_ase_pkg::*;

    agu_t st;
    agu_t next_st;

    // base plus index scaled by four, alignment checked on the sum
    always_comb begin
        next_st = st;
        next_st.valid = start;
        if (start) begin
            next_st.addr = baseValue + (indexValue << SCALE_SHIFT);
            next_st.fault = (next_st.addr[1:0] != 2'h0);
        end
    end

    // state register, synchronous reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign addrValid = st.valid;
    assign addr = st.addr;
    assign addrFault = st.fault;
endmodule
`default_nettype wire

// ===== core/crypto_ase_instruction_decode.sv
// instruction decoder and config reporting for the crypto extension
`default_nettype none
module crypto_ase_instruction_decode #(
    parameter bit EXT_IMPL = 1'b1,
    parameter bit DEBUG_IMPL = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instrValid,
    input wire logic [31:0] instrWord,
    input wire logic [31:0] operandBase,
    input wire logic [31:0] operandIndex,
    input wire logic [3:0] copUsable,
    input wire logic [1:0] archRelease,
    output logic decValid,
    output crypto_ase_pkg::dec_op_t decOp,
    output crypto_ase_pkg::ctl_t decCtl,
    output logic resInstrExc,
    output logic coprocUnusableExc,
    output logic [1:0] coprocUnit,
    output logic loadAddrValid,
    output logic [31:0] loadAddr,
    output logic loadAddrErr,
    output crypto_ase_pkg::cfg_t cfg
);
    import crypto_ase_pkg::*;

    typedef struct packed {
        logic valid;
        dec_op_t op;
        ctl_t ctl;
        logic ri;
        logic cpu;
        logic [1:0] unit;
        cfg_t cfg;
    } st_t;

    st_t st;
    st_t next_st;
    dec_t dec;
    logic loadStart;

    // major opcode field of a word
    function automatic logic [5:0] opcOf(input logic [31:0] w);
        return w[31:26];
    endfunction

    // function field of a word
    function automatic logic [5:0] fnOf(input logic [31:0] w);
        return w[5:0];
    endfunction

    // shift-amount field, which also qualifies several groups
    function automatic logic [4:0] saOf(input logic [31:0] w);
        return w[10:6];
    endfunction

    // opcodes and functions that only exist on the 64-bit ISA level
    function automatic logic isWideOnly(input logic [31:0] w);
        logic [5:0] opc;
        logic [5:0] fn;
        logic hit;
        opc = opcOf(w);
        fn = fnOf(w);
        hit = 1'b0;
        case (opc)
            6'h18, 6'h19, 6'h1a, 6'h1b, 6'h27, 6'h2c, 6'h2d, 6'h34, 6'h37, 6'h3c, 6'h3f: hit = 1'b1;
            OPC_FIRST_SPECIAL: begin
                case (fn)
                    6'h14, 6'h16, 6'h17, 6'h1c, 6'h1d, 6'h1e, 6'h1f,
                    6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h38, 6'h3a, 6'h3b,
                    6'h3c, 6'h3e, 6'h3f: hit = 1'b1;
                    default: hit = 1'b0;
                endcase
            end
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // true for results that only the extension provides
    function automatic logic isExtOnly(input dec_op_t op);
        case (op)
            OP_ROTATE_RIGHT_IMM, OP_ROTATE_RIGHT_VAR, OP_MOVE_FROM_EXT_ACCUM,
            OP_MOVE_TO_EXT_ACCUM, OP_POLY_MULTIPLY, OP_POLY_MULTIPLY_ADD,
            OP_PARTIAL_PERMUTE, OP_SCALED_INDEXED_WORD_LOAD: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // full classification of one instruction word
    function automatic dec_t classify(input logic [31:0] w, input logic [3:0] usable);
        dec_t d;
        logic [5:0] opc;
        logic [5:0] fn;
        logic [4:0] sa;
        d = '0;
        d.op = OP_NONE;
        opc = opcOf(w);
        fn = fnOf(w);
        sa = saOf(w);
        case (opc)
            OPC_FIRST_SPECIAL: begin
                case (fn)
                    FN_SHIFT_RIGHT_LOGICAL: begin
                        if (w[25:22] != 4'h0) begin
                            d.resInstr = 1'b1;
                        end else if (w[ROT_IMM_BIT]) begin
                            d.op = OP_ROTATE_RIGHT_IMM;
                        end else begin
                            d.op = OP_SHIFT_RIGHT_LOGICAL;
                        end
                    end
                    FN_SHIFT_RIGHT_VARIABLE: begin
                        if (w[10:7] != 4'h0) begin
                            d.resInstr = 1'b1;
                        end else if (w[ROT_VAR_BIT]) begin
                            d.op = OP_ROTATE_RIGHT_VAR;
                        end else begin
                            d.op = OP_SHIFT_RIGHT_VARIABLE;
                        end
                    end
                    FN_MOVE_FROM_LOW: begin
                        case (sa)
                            SA_PLAIN: d.op = OP_MOVE_FROM_LOW;
                            SA_EXT_ACCUM: d.op = OP_MOVE_FROM_EXT_ACCUM;
                            default: d.resInstr = 1'b1;
                        endcase
                    end
                    FN_MOVE_TO_LOW: begin
                        case (sa)
                            SA_PLAIN: d.op = OP_MOVE_TO_LOW;
                            SA_EXT_ACCUM: d.op = OP_MOVE_TO_EXT_ACCUM;
                            default: d.resInstr = 1'b1;
                        endcase
                    end
                    FN_UNSIGNED_MULTIPLY: begin
                        case (sa)
                            SA_PLAIN: d.op = OP_UNSIGNED_MULTIPLY;
                            SA_POLY: d.op = OP_POLY_MULTIPLY;
                            default: d.resInstr = 1'b1;
                        endcase
                    end
                    default: d.op = OP_NONE;
                endcase
            end
            OPC_SECOND_SPECIAL: begin
                case (fn)
                    FN_UNSIGNED_MULTIPLY_ADD: begin
                        case (sa)
                            SA_PLAIN: d.op = OP_UNSIGNED_MULTIPLY_ADD;
                            SA_POLY: d.op = OP_POLY_MULTIPLY_ADD;
                            SA_PERMUTE: d.op = OP_PARTIAL_PERMUTE;
                            default: d.resInstr = 1'b1;
                        endcase
                    end
                    FN_INDEXED_LOAD_GROUP: begin
                        if (sa == SA_SCALED_WORD) begin
                            d.op = OP_SCALED_INDEXED_WORD_LOAD;
                        end else begin
                            d.resInstr = 1'b1;
                        end
                    end
                    FN_DEBUG_BREAK: begin
                        if (DEBUG_IMPL) begin
                            d.op = OP_DEBUG_BREAK;
                        end else begin
                            d.resInstr = 1'b1;
                        end
                    end
                    default: d.resInstr = 1'b1;
                endcase
            end
            default: begin
                if (opc[5:2] == OPC_COPROC_HI && !usable[opc[1:0]]) begin
                    d.coprocUnusable = 1'b1;
                    d.unit = opc[1:0];
                end
            end
        endcase
        if (isWideOnly(w)) begin
            d.resInstr = 1'b1;
            d.op = OP_NONE;
        end
        if (!EXT_IMPL && isExtOnly(d.op)) begin
            d.resInstr = 1'b1;
            d.op = OP_NONE;
        end
        return d;
    endfunction

    // execute-stage steering for a decoded operation
    function automatic ctl_t ctlOf(input dec_op_t op);
        ctl_t c;
        c = '0;
        case (op)
            OP_MOVE_FROM_EXT_ACCUM: begin
                c.writesGpr = 1'b1;
                c.gprFromLo = 1'b1;
                c.loFromHi = 1'b1;
                c.hiFromAcxZext = 1'b1;
            end
            OP_MOVE_FROM_LOW: begin
                c.writesGpr = 1'b1;
                c.gprFromLo = 1'b1;
            end
            OP_MOVE_TO_EXT_ACCUM: begin
                c.loFromGpr = 1'b1;
                c.hiFromLo = 1'b1;
                c.acxFromHi = 1'b1;
            end
            OP_MOVE_TO_LOW: c.loFromGpr = 1'b1;
            OP_UNSIGNED_MULTIPLY: c.clearsAcx = 1'b1;
            OP_POLY_MULTIPLY, OP_POLY_MULTIPLY_ADD: c.polyArith = 1'b1;
            OP_PARTIAL_PERMUTE: c.accumShift = PERMUTE_BITS;
            OP_SCALED_INDEXED_WORD_LOAD: begin
                c.writesGpr = 1'b1;
                c.indexShift = SCALE_SHIFT;
            end
            OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_RIGHT_IMM,
            OP_SHIFT_RIGHT_VARIABLE, OP_ROTATE_RIGHT_VAR: c.writesGpr = 1'b1;
            default: c = '0;
        endcase
        return c;
    endfunction

    // config bits advertised for the current base release
    function automatic cfg_t cfgOf(input logic [1:0] rel);
        cfg_t c;
        c = '0;
        c.smallPage = 1'b0;
        c.readExecInhibit = (rel >= REL_THREE);
        c.readInhibitWritable = (rel >= REL_THREE);
        c.execInhibitWritable = (rel >= REL_THREE);
        c.contextCfgPresent = (rel >= REL_THREE);
        c.extensionPresent = EXT_IMPL;
        c.page2kSupport = 1'b1;
        c.page1kSupport = 1'b1;
        c.readOnlyProt = 1'b1;
        c.writeOnlyProt = 1'b1;
        c.execOnlyProt = 1'b1;
        return c;
    endfunction

    // combinational classification of the incoming word
    always_comb begin
        dec = classify(instrWord, copUsable);
    end

    // next state: one decode per valid word, results cleared when no word is valid
    always_comb begin
        next_st = st;
        next_st.cfg = cfgOf(archRelease);
        next_st.valid = instrValid;
        if (instrValid) begin
            next_st.op = dec.op;
            next_st.ctl = ctlOf(dec.op);
            next_st.ri = dec.resInstr;
            next_st.cpu = dec.coprocUnusable;
            next_st.unit = dec.unit;
        end else begin
            next_st.op = OP_NONE;
            next_st.ctl = '0;
            next_st.ri = 1'b0;
            next_st.cpu = 1'b0;
            next_st.unit = 2'h0;
        end
    end

    // state register, synchronous reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // only a legal scaled load starts the address generator
    assign loadStart = instrValid && dec.op == OP_SCALED_INDEXED_WORD_LOAD;

    // scaled load address, aligned with the registered decode
    scaled_load_agu agu (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(loadStart),
        .baseValue(operandBase),
        .indexValue(operandIndex),
        .addrValid(loadAddrValid),
        .addr(loadAddr),
        .addrFault(loadAddrErr)
    );

    // registered outputs
    assign decValid = st.valid;
    assign decOp = st.op;
    assign decCtl = st.ctl;
    assign resInstrExc = st.ri;
    assign coprocUnusableExc = st.cpu;
    assign coprocUnit = st.unit;
    assign cfg = st.cfg;
endmodule
`default_nettype wire

// ===== verif/fetch_stage_model.sv
// fetch-stage model that feeds instruction words and operands to the decoder
`default_nettype none
module fetch_stage_model (
    input wire logic core_clk,
    input wire logic send,
    input wire logic [95:0] sendBundle,
    output logic instrValid,
    output logic [95:0] bundle
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [95:0] held = '0;
    // idle lines flip every cycle so a stale word is never taken for a fresh one
    always @(posedge core_clk) begin
        held <= send ? ~sendBundle : ~held;
    end
    // word, base and index travel together with the valid flag
    assign instrValid = send;
    assign bundle = send ? sendBundle : held;
endmodule
`default_nettype wire

// ===== verif/crypto_ase_asserts.sv
// concurrent checks on the decoder ports
`default_nettype none
module crypto_ase_asserts #(
    parameter bit EXT_IMPL = 1'b1,
    parameter bit DEBUG_IMPL = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instrValid,
    input wire logic [31:0] instrWord,
    input wire logic [31:0] operandBase,
    input wire logic [31:0] operandIndex,
    input wire logic [3:0] copUsable,
    input wire logic [1:0] archRelease,
    input wire logic decValid,
    input wire crypto_ase_pkg::dec_op_t decOp,
    input wire crypto_ase_pkg::ctl_t decCtl,
    input wire logic resInstrExc,
    input wire logic coprocUnusableExc,
    input wire logic [1:0] coprocUnit,
    input wire logic loadAddrValid,
    input wire logic [31:0] loadAddr,
    input wire logic loadAddrErr,
    input wire crypto_ase_pkg::cfg_t cfg
);
    timeunit 1ns;
    timeprecision 1ps;
    import crypto_ase_pkg::*;
    logic takeV;
    logic [31:0] takeW;
    logic [3:0] takeCu;
    logic first;
    logic second;
    // word accepted at the previous edge, lined up with the registered result
    always_ff @(posedge core_clk) begin
        takeV <= rst_n && instrValid;
        takeW <= instrWord;
        takeCu <= copUsable;
    end
    assign first = takeV && takeW[31:26] == OPC_FIRST_SPECIAL;
    assign second = takeV && takeW[31:26] == OPC_SECOND_SPECIAL;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_valid_follow: assert property (decValid == takeV)
        else $error("result valid does not follow accepted word");
    chk_rotate_imm: assert property (first && takeW[5:0] == FN_SHIFT_RIGHT_LOGICAL && takeW[25:21] == 5'h01
        |-> decOp == OP_ROTATE_RIGHT_IMM) else $error("immediate rotate not decoded");
    chk_rotate_var: assert property (first && takeW[5:0] == FN_SHIFT_RIGHT_VARIABLE && takeW[10:6] == 5'h01
        |-> decOp == OP_ROTATE_RIGHT_VAR) else $error("variable rotate not decoded");
    chk_ext_accum: assert property (first && takeW[5:0] == FN_MOVE_FROM_LOW
        && takeW[10:6] == SA_EXT_ACCUM
        |-> decOp == OP_MOVE_FROM_EXT_ACCUM && decCtl.gprFromLo && decCtl.loFromHi && decCtl.hiFromAcxZext)
        else $error("move from extended accumulator wrong");
    chk_permute_six: assert property (second && takeW[5:0] == FN_UNSIGNED_MULTIPLY_ADD
        && takeW[10:6] == SA_PERMUTE |-> decOp == OP_PARTIAL_PERMUTE && decCtl.accumShift == PERMUTE_BITS)
        else $error("partial permute wrong");
    chk_reserved_amount: assert property (second && takeW[5:0] == FN_INDEXED_LOAD_GROUP
        && takeW[10:6] != SA_SCALED_WORD |-> resInstrExc && decOp == OP_NONE) else $error("reserved amount accepted");
    chk_cop_unusable: assert property (takeV && takeW[31:28] == OPC_COPROC_HI && !takeCu[takeW[27:26]]
        |-> coprocUnusableExc && coprocUnit == takeW[27:26]) else $error("coprocessor unusable missing");
    chk_load_addr: assert property (loadAddrValid
        |-> loadAddr == $past(operandBase) + ($past(operandIndex) << 2) && loadAddrErr == (loadAddr[1:0] != 2'h0))
        else $error("scaled load address wrong");
    chk_release_cfg: assert property ($past(rst_n) |-> !cfg.smallPage
        && cfg.extensionPresent == EXT_IMPL && cfg.readExecInhibit == ($past(archRelease) == REL_THREE))
        else $error("config bits wrong");
endmodule
bind crypto_ase_instruction_decode crypto_ase_asserts #(.EXT_IMPL(EXT_IMPL), .DEBUG_IMPL(DEBUG_IMPL)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord),
    .operandBase(operandBase), .operandIndex(operandIndex), .copUsable(copUsable), .archRelease(archRelease),
    .decValid(decValid), .decOp(decOp), .decCtl(decCtl), .resInstrExc(resInstrExc),
    .coprocUnusableExc(coprocUnusableExc), .coprocUnit(coprocUnit), .loadAddrValid(loadAddrValid),
    .loadAddr(loadAddr), .loadAddrErr(loadAddrErr), .cfg(cfg)
);
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the crypto extension decoder
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import crypto_ase_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic send = 1'b0;
    logic [95:0] sendBundle = '0;
    logic [3:0] copUsable = 4'hf;
    logic [1:0] archRelease = 2'h1;
    logic instrValid, decValid, resInstrExc, coprocUnusableExc, loadAddrValid, loadAddrErr;
    logic [31:0] instrWord, operandBase, operandIndex, loadAddr;
    logic [1:0] coprocUnit;
    dec_op_t decOp;
    ctl_t decCtl;
    cfg_t cfg;
    int err_count = 0;
    int comparisons = 0;
    integer seed = 32'hecdaed15;
    logic prevV = 1'b0;
    logic [95:0] prevB = '0;
    logic [3:0] prevCu = 4'hf;
    logic [1:0] prevRel = 2'h1;
    always #5 core_clk = ~core_clk;
    fetch_stage_model u_fetch_stage_model (.core_clk(core_clk), .send(send), .sendBundle(sendBundle),
        .instrValid(instrValid), .bundle({instrWord, operandBase, operandIndex}));
    crypto_ase_instruction_decode u_crypto_ase_instruction_decode (.core_clk(core_clk), .rst_n(rst_n),
        .instrValid(instrValid), .instrWord(instrWord), .operandBase(operandBase), .operandIndex(operandIndex),
        .copUsable(copUsable), .archRelease(archRelease), .decValid(decValid), .decOp(decOp), .decCtl(decCtl),
        .resInstrExc(resInstrExc), .coprocUnusableExc(coprocUnusableExc), .coprocUnit(coprocUnit),
        .loadAddrValid(loadAddrValid), .loadAddr(loadAddr), .loadAddrErr(loadAddrErr), .cfg(cfg));
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cmp_op(input dec_op_t got, input dec_op_t exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t op got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // expected decode of one word under the given coprocessor access mask
    function automatic dec_t exp_dec(input logic [31:0] w, input logic [3:0] cu);
        dec_t d;
        dec_op_t o;
        logic r;
        logic [4:0] sa;
        d = '0;
        o = OP_NONE;
        r = 1'b0;
        sa = w[10:6];
        if (w[31:26] == OPC_FIRST_SPECIAL) begin
            case (w[5:0])
                FN_SHIFT_RIGHT_LOGICAL: begin
                    o = w[ROT_IMM_BIT] ? OP_ROTATE_RIGHT_IMM : OP_SHIFT_RIGHT_LOGICAL;
                    r = w[25:22] != 4'h0;
                end
                FN_SHIFT_RIGHT_VARIABLE: begin
                    o = w[ROT_VAR_BIT] ? OP_ROTATE_RIGHT_VAR : OP_SHIFT_RIGHT_VARIABLE;
                    r = w[10:7] != 4'h0;
                end
                FN_MOVE_FROM_LOW: begin
                    o = sa == SA_EXT_ACCUM ? OP_MOVE_FROM_EXT_ACCUM : OP_MOVE_FROM_LOW;
                    r = sa > SA_EXT_ACCUM;
                end
                FN_MOVE_TO_LOW: begin
                    o = sa == SA_EXT_ACCUM ? OP_MOVE_TO_EXT_ACCUM : OP_MOVE_TO_LOW;
                    r = sa > SA_EXT_ACCUM;
                end
                FN_UNSIGNED_MULTIPLY: begin
                    o = sa == SA_POLY ? OP_POLY_MULTIPLY : OP_UNSIGNED_MULTIPLY;
                    r = sa != SA_PLAIN && sa != SA_POLY;
                end
                default: r = 1'b0;
            endcase
        end else if (w[31:26] == OPC_SECOND_SPECIAL) begin
            case (w[5:0])
                FN_UNSIGNED_MULTIPLY_ADD: begin
                    o = sa == SA_POLY ? OP_POLY_MULTIPLY_ADD : sa == SA_PERMUTE ? OP_PARTIAL_PERMUTE
                        : OP_UNSIGNED_MULTIPLY_ADD;
                    r = !(sa inside {SA_PLAIN, SA_POLY, SA_PERMUTE});
                end
                FN_INDEXED_LOAD_GROUP: begin
                    o = OP_SCALED_INDEXED_WORD_LOAD;
                    r = sa != SA_SCALED_WORD;
                end
                default: r = 1'b1;
            endcase
        end else if (w[31:28] == OPC_COPROC_HI) begin
            d.coprocUnusable = !cu[w[27:26]];
            d.unit = d.coprocUnusable ? w[27:26] : 2'h0;
        end
        // words that only exist on the wider ISA level
        if (w[31:26] inside {6'h18, 6'h19, 6'h1a, 6'h1b, 6'h27, 6'h2c, 6'h2d, 6'h34, 6'h37, 6'h3c, 6'h3f}
            || (w[31:26] == OPC_FIRST_SPECIAL && w[5:0] inside {6'h14, 6'h16, 6'h17, 6'h1c, 6'h1d, 6'h1e,
            6'h1f, 6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h38, 6'h3a, 6'h3b, 6'h3c, 6'h3e, 6'h3f})) begin
            r = 1'b1;
        end
        d.op = r ? OP_NONE : o;
        d.resInstr = r;
        return d;
    endfunction
    // expected execute steering of one decoded op
    function automatic ctl_t exp_ctl(input dec_op_t o);
        ctl_t c;
        c = '0;
        c.writesGpr = o inside {OP_MOVE_FROM_LOW, OP_MOVE_FROM_EXT_ACCUM, OP_SCALED_INDEXED_WORD_LOAD,
            OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_RIGHT_IMM, OP_SHIFT_RIGHT_VARIABLE, OP_ROTATE_RIGHT_VAR};
        c.gprFromLo = o inside {OP_MOVE_FROM_LOW, OP_MOVE_FROM_EXT_ACCUM};
        {c.loFromHi, c.hiFromAcxZext} = {2{o == OP_MOVE_FROM_EXT_ACCUM}};
        c.loFromGpr = o inside {OP_MOVE_TO_LOW, OP_MOVE_TO_EXT_ACCUM};
        {c.hiFromLo, c.acxFromHi} = {2{o == OP_MOVE_TO_EXT_ACCUM}};
        c.clearsAcx = o == OP_UNSIGNED_MULTIPLY;
        c.polyArith = o inside {OP_POLY_MULTIPLY, OP_POLY_MULTIPLY_ADD};
        c.accumShift = o == OP_PARTIAL_PERMUTE ? PERMUTE_BITS : 3'h0;
        c.indexShift = o == OP_SCALED_INDEXED_WORD_LOAD ? SCALE_SHIFT : 2'h0;
        return c;
    endfunction
    // random word aimed at the decoded classes, qualifier fields mostly legal
    function automatic logic [31:0] gen();
        logic [31:0] w;
        logic [4:0] saPick [4] = '{5'h00, 5'h01, 5'h11, 5'h12};
        logic [5:0] fnTab [7] = '{FN_SHIFT_RIGHT_LOGICAL, FN_SHIFT_RIGHT_VARIABLE, FN_MOVE_FROM_LOW,
            FN_MOVE_TO_LOW, FN_UNSIGNED_MULTIPLY, FN_UNSIGNED_MULTIPLY_ADD, FN_INDEXED_LOAD_GROUP};
        int k;
        w = $random(seed);
        k = $unsigned($random(seed)) % 10;
        if (w[14:13] != 2'h0) begin
            w[10:6] = saPick[w[1:0]];
        end
        w[31:26] = k < 5 ? OPC_FIRST_SPECIAL : k < 8 ? OPC_SECOND_SPECIAL : k == 8 ? {OPC_COPROC_HI, w[27:26]}
            : {w[29] ? 3'h6 : 3'h1, w[28:26]};
        if (k < 7) begin
            w[5:0] = fnTab[k];
        end
        if (k < 2 && w[12]) begin
            w[25:22] = 4'h0;
            w[10:7] = 4'h0;
        end
        return w;
    endfunction
    // drives one cycle and checks the result of the word sent one cycle earlier
    task automatic step(input logic v, input logic [95:0] b);
        dec_t e;
        logic [31:0] a;
        @(posedge core_clk);
        send <= v;
        sendBundle <= b;
        copUsable <= 4'($random(seed));
        archRelease <= 2'(2'h1 + $unsigned($random(seed)) % 3);
        @(negedge core_clk);
        e = exp_dec(prevB[95:64], prevCu);
        a = prevB[63:32] + {prevB[29:0], 2'h0};
        cmp_val(decValid, prevV);
        cmp_val(cfg, {1'b0, {4{prevRel == REL_THREE}}, 6'h3f});
        cmp_val(loadAddrValid, prevV && e.op == OP_SCALED_INDEXED_WORD_LOAD);
        cmp_val(decCtl, exp_ctl(prevV ? e.op : OP_NONE));
        if (prevV) begin
            cmp_op(decOp, e.op);
            cmp_val({resInstrExc, coprocUnusableExc, coprocUnit},
                {e.resInstr, e.coprocUnusable, e.unit});
            if (e.op == OP_SCALED_INDEXED_WORD_LOAD) begin
                cmp_val(loadAddr, a);
                cmp_val(loadAddrErr, a[1:0] != 2'h0);
            end
        end
        prevV = v;
        prevB = b;
        prevCu = copUsable;
        prevRel = archRelease;
    endtask
    // reset, hand-written corners back to back, then random traffic
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        step(1'b1, {32'h00200042, 64'h0});
        step(1'b1, {32'h70000048, 32'h100, 32'h3});
        step(1'b1, {32'h70000048, 32'h101, 32'h7});
        step(1'b1, {32'h7000007f, 64'h0});
        step(1'b1, {32'h70000488, 64'h0});
        step(1'b1, {32'hdc000000, 64'h0});
        step(1'b1, {32'h0000002d, 64'h0});
        step(1'b0, '0);
        repeat (600) begin
            step($unsigned($random(seed)) % 4 != 0, {gen(), 32'($random(seed)), 32'($random(seed))});
        end
        step(1'b0, '0);
        step(1'b0, '0);
        finish_test();
    end
    // the run needs about 620 cycles; ten times that marks a hang
    initial begin
        #62000;
        err_count++;
        finish_test();
    end
endmodule
`default_nettype wire
